// File: rtl/eid_decoder.sv
// Summary of operation
// - Byte A5 opens every extended instruction; next byte is an extended op.
// - Breakpoint with debug enabled halts, PC left at next instruction.
// - Breakpoint with debug disabled is a two-cycle no-op, PC plus two.
// - Arithmetic right shift of accumulator keeps bit 39, two cycles.
// - Clear sets all forty accumulator bits to zero in two cycles.
// - Indirect compare sets carry when accumulator below byte, else clears.
// - Unequal compare branches to advanced PC plus signed displacement.
// - Every compare-and-jump form takes four cycles.
// - Alternate pointer increments modulo 65536 in three cycles.
// - Indirect jump loads PC plus two plus accumulator, three cycles.
// - External moves: 2 or 4 cycles, alternate pointer 3 or 5.
// - Calls and returns take extra cycles with the extended stack.
`timescale 1ns/1ps
`include "eid_map.svh"

module eid_decoder
  import eid_pkg::*;
(
  input logic i_clk,               // Core clock, 50 MHz
  input logic i_rstn,              // Sync reset, active low
  input logic i_byte_valid,        // Code byte present
  input logic [7:0] i_byte,        // Code byte
  input logic [7:0] i_acc,         // Core accumulator
  input logic [7:0] i_ind_byte,    // RAM byte at @Ri
  input logic i_ptr_sel,           // pointer_select
  input logic i_debug_en,          // debug_unit enabled
  input logic i_resume,            // Leave debug halt
  input logic i_ext_stack,         // Extended stack in use
  input logic i_fast_space,        // Move targets extra_ram
  input logic i_pc_load,           // Core PC write
  input logic [15:0] i_pc_val,     // Core PC value
  input logic [1:0] i_dp_we,       // Pointer writes, bit per ptr
  input logic [15:0] i_dp_wdata,   // Pointer write data
  output logic o_byte_ready,       // Next byte will be taken
  output logic [15:0] o_pc,        // Program counter
  output logic [15:0] o_data_pointer_zero,     // data_pointer_zero
  output logic [15:0] o_data_pointer_one,     // data_pointer_one
  output logic o_ind_sel,          // Which Ri for @Ri
  output logic o_carry,            // Carry flag value
  output logic o_carry_we,         // Carry write pulse
  output logic o_halt,             // In debug handler
  output eid_retire_type o_retire, // Finished instruction
  output logic [39:0] o_mac        // mac_accumulator
);

  // ========================================================
  // Cycle count of an instruction from its opcode
  function automatic logic [2:0] cyc_of(input logic esc,
    input logic [7:0] op, input logic xs, input logic fast);
    logic [2:0] c;
    c = `EID_CYC_STD;
    if (esc) begin
      case (op)
        `EID_OP_CJ0, `EID_OP_CJ1: c = `EID_CYC_CJ;
        `EID_OP_INCA: c = `EID_CYC_INCA;
        `EID_OP_JMPA: c = `EID_CYC_JMPA;
        `EID_OP_MVXR, `EID_OP_MVXW: begin
          c = fast ? `EID_CYC_AMVX_F : `EID_CYC_AMVX_S;
        end
        default: c = `EID_CYC_TWO;
      endcase
    end else if (op == `EID_OP_MVXR || op == `EID_OP_MVXW) begin
      c = fast ? `EID_CYC_MVX_F : `EID_CYC_MVX_S;
    end else if (op[4:0] == `EID_ACALL_LOW) begin
      c = xs ? `EID_CYC_ACALL_X : `EID_CYC_ACALL;
    end else if (op == `EID_OP_LCALL) begin
      c = xs ? `EID_CYC_LCALL_X : `EID_CYC_LCALL;
    end else if (op == `EID_OP_RET || op == `EID_OP_RETI) begin
      c = xs ? `EID_CYC_RET_X : `EID_CYC_RET;
    end else if (op[7:4] == 4'hB && op[3:2] != 2'h0) begin
      c = `EID_CYC_CJ;
    end
    return c;
  endfunction

  eid_state_type state, next_state;
  logic [15:0] pc, next_pc;
  logic [2:0] cnt, next_cnt;
  logic [2:0] tot, next_tot;
  logic [7:0] op, next_op;
  logic esc, next_esc;
  logic [7:0] rel, next_rel;
  logic [15:0] dp0, next_dp0;
  logic [15:0] dp1, next_dp1;
  logic ind_sel, next_ind_sel;
  logic carry, next_carry;
  logic carry_we, next_carry_we;
  logic halt, next_halt;
  logic ready, next_ready;
  eid_retire_type retire, next_retire;
  eid_mac_cmd_type mac_cmd;
  logic fin;
  logic [15:0] rel_ext;

  // Sign-extended branch displacement
  assign rel_ext = {{8{rel[7]}}, rel};

  // ========================================================
  // Sequencer: one code byte per cycle, effects on last cycle
  always_comb begin
    next_state = state;
    next_pc = pc;
    next_cnt = cnt;
    next_tot = tot;
    next_op = op;
    next_esc = esc;
    next_rel = rel;
    next_ind_sel = ind_sel;
    next_carry = carry;
    next_carry_we = 1'b0;
    next_halt = halt;
    next_retire = '0;
    mac_cmd = '0;
    fin = 1'b0;
    // Core pointer writes; an increment below lands on top
    next_dp0 = i_dp_we[0] ? i_dp_wdata : dp0;
    next_dp1 = i_dp_we[1] ? i_dp_wdata : dp1;
    case (state)
      ST_IDLE: begin
        if (i_pc_load) begin
          next_pc = i_pc_val;      // Core jump wins over a fetch
        end else if (i_byte_valid) begin
          next_pc = pc + 16'h0001;
          next_op = i_byte;
          next_cnt = 3'h1;
          if (i_byte == `EID_OP_ESC) begin
            next_esc = 1'b1;
            next_state = ST_ESC;
          end else begin
            next_esc = 1'b0;
            next_tot = cyc_of(1'b0, i_byte, i_ext_stack,
                              i_fast_space);
            if (next_tot == `EID_CYC_STD) begin
              fin = 1'b1;
            end else begin
              next_state = ST_WAIT;
            end
          end
        end
      end
      ST_ESC: begin
        if (i_byte_valid) begin
          next_pc = pc + 16'h0001;
          next_op = i_byte;
          next_cnt = 3'h2;
          next_ind_sel = i_byte[0];
          next_tot = cyc_of(1'b1, i_byte, i_ext_stack,
                            i_fast_space);
          if (i_byte == `EID_OP_CJ0 || i_byte == `EID_OP_CJ1) begin
            next_state = ST_REL;
          end else if (next_tot == `EID_CYC_TWO) begin
            fin = 1'b1;
          end else begin
            next_state = ST_WAIT;
          end
        end
      end
      ST_REL: begin
        if (i_byte_valid) begin
          next_pc = pc + 16'h0001;
          next_rel = i_byte;
          next_cnt = 3'h3;
          next_state = ST_WAIT;
        end
      end
      ST_WAIT: begin
        next_cnt = cnt + 3'h1;
        fin = (next_cnt == tot);
      end
      ST_HALT: begin
        if (i_resume) begin
          next_halt = 1'b0;
          next_state = ST_IDLE;
        end
      end
      default: next_state = ST_IDLE;
    endcase
    // Last cycle of an instruction: apply its effect
    if (fin) begin
      next_state = ST_IDLE;
      next_retire = {1'b1, next_esc, next_op, next_tot};
      if (next_esc) begin
        case (next_op)
          `EID_OP_BRK: begin
            if (i_debug_en) begin
              next_halt = 1'b1;
              next_state = ST_HALT;
            end                    // Else a plain no-op
          end
          `EID_OP_ASR: mac_cmd.asr = 1'b1;
          `EID_OP_CLR: mac_cmd.clr = 1'b1;
          `EID_OP_CJ0, `EID_OP_CJ1: begin
            next_carry = i_acc < i_ind_byte;
            next_carry_we = 1'b1;
            if (i_acc != i_ind_byte) begin
              next_pc = pc + rel_ext;
            end
          end
          `EID_OP_INCA: begin
            if (i_ptr_sel) begin
              next_dp0 = dp0 + 16'h0001;
            end else begin
              next_dp1 = dp1 + 16'h0001;
            end
          end
          `EID_OP_JMPA: next_pc = pc + {8'h00, i_acc};
          default: ;
        endcase
      end
    end
    next_ready = (next_state == ST_IDLE) || (next_state == ST_ESC) ||
                 (next_state == ST_REL);
  end

  // Registers only
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      state <= ST_IDLE;
      pc <= `EID_PC_RST;
      dp0 <= `EID_DP_RST;
      dp1 <= `EID_DP_RST;
      {cnt, tot} <= 6'h00;
      {op, rel} <= 16'h0000;
      {esc, ind_sel, carry, carry_we, halt, ready} <= 6'h00;
      retire <= '0;
    end else begin
      state <= next_state;
      pc <= next_pc;
      cnt <= next_cnt;
      tot <= next_tot;
      op <= next_op;
      esc <= next_esc;
      rel <= next_rel;
      dp0 <= next_dp0;
      dp1 <= next_dp1;
      ind_sel <= next_ind_sel;
      carry <= next_carry;
      carry_we <= next_carry_we;
      halt <= next_halt;
      ready <= next_ready;
      retire <= next_retire;
    end
  end

  // ========================================================
  // Accumulator kept in its own register module
  eid_mac_acc u_mac (
    .i_clk(i_clk),
    .i_rstn(i_rstn),
    .i_cmd(mac_cmd),
    .o_acc(o_mac)
  );

  // Outputs straight from flops
  assign o_byte_ready = ready;
  assign o_pc = pc;
  assign {o_data_pointer_zero, o_data_pointer_one} = {dp0, dp1};
  assign {o_ind_sel, o_halt} = {ind_sel, halt};
  assign {o_carry, o_carry_we} = {carry, carry_we};
  assign o_retire = retire;

  // ========================================================
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  property p_esc_take;
    state == ST_IDLE && i_byte_valid && !i_pc_load &&
    i_byte == `EID_OP_ESC |=> state == ST_ESC;
  endproperty
  a_esc_take: assert property (p_esc_take)
    else $error("escape byte not taken as prefix");
  property p_brk_halt;
    state == ST_ESC && i_byte_valid && i_byte == `EID_OP_BRK &&
    i_debug_en |=> o_halt && o_pc == $past(pc) + 16'h0001;
  endproperty
  a_brk_halt: assert property (p_brk_halt)
    else $error("breakpoint did not halt at next address");
  property p_brk_nop;
    state == ST_ESC && i_byte_valid && i_byte == `EID_OP_BRK &&
    !i_debug_en |=> !o_halt && !o_carry_we && o_retire.done &&
    o_retire.cycles == 3'h2 && state == ST_IDLE;
  endproperty
  a_brk_nop: assert property (p_brk_nop)
    else $error("disabled breakpoint not a two-cycle no-op");
  property p_cj_carry;
    state == ST_WAIT && fin && esc && op[7:1] == 7'h5B |=>
    o_carry_we && o_carry == ($past(i_acc) < $past(i_ind_byte));
  endproperty
  a_cj_carry: assert property (p_cj_carry)
    else $error("compare carry wrong");
  property p_cj_pc;
    state == ST_WAIT && fin && esc && op[7:1] == 7'h5B &&
    i_acc != i_ind_byte |=> o_pc == $past(pc) + $past(rel_ext);
  endproperty
  a_cj_pc: assert property (p_cj_pc)
    else $error("compare branch target wrong");
  property p_cj_four;
    state == ST_IDLE && i_byte_valid && !i_pc_load &&
    i_byte == `EID_OP_ESC ##1 i_byte_valid &&
    i_byte == `EID_OP_CJ0 ##1 i_byte_valid |=>
    !o_retire.done ##1 o_retire.done && o_retire.cycles == 3'h4;
  endproperty
  a_cj_four: assert property (p_cj_four)
    else $error("indirect compare not four cycles");
  property p_inc_alt;
    state == ST_WAIT && fin && esc && op == `EID_OP_INCA && !i_ptr_sel &&
    i_dp_we == 2'h0 |=> o_data_pointer_one == $past(dp1) + 16'h0001 &&
    o_data_pointer_zero == $past(dp0) && o_retire.cycles == 3'h3;
  endproperty
  a_inc_alt: assert property (p_inc_alt)
    else $error("alternate pointer increment wrong");
  property p_jmp_pc;
    state == ST_WAIT && fin && esc && op == `EID_OP_JMPA |=>
    o_pc == $past(pc) + {8'h00, $past(i_acc)} && !o_carry_we;
  endproperty
  a_jmp_pc: assert property (p_jmp_pc)
    else $error("indirect jump target wrong");
  property p_movx_fast;
    state == ST_IDLE && i_byte_valid && !i_pc_load &&
    i_byte == `EID_OP_MVXR && i_fast_space |=>
    !o_retire.done ##1 o_retire.done && o_retire.cycles == 3'h2;
  endproperty
  a_movx_fast: assert property (p_movx_fast)
    else $error("fast external move not two cycles");
  property p_lcall_ext;
    state == ST_IDLE && i_byte_valid && !i_pc_load &&
    i_byte == `EID_OP_LCALL && i_ext_stack |=>
    ##5 o_retire.done && o_retire.cycles == 3'h6;
  endproperty
  a_lcall_ext: assert property (p_lcall_ext)
    else $error("long call on extended stack not six cycles");

endmodule

// File: rtl/eid_mac_acc.sv
`timescale 1ns/1ps
`include "eid_map.svh"

module eid_mac_acc
  import eid_pkg::*;
(
  input logic i_clk,               // Core clock
  input logic i_rstn,              // Sync reset, active low
  input eid_mac_cmd_type i_cmd,    // Clear or shift strobe
  output logic [39:0] o_acc        // Accumulator contents
);

  logic [39:0] acc;
  logic [39:0] next_acc;
  logic [39:0] asr_val;

  // ========================================================
  // Next value: clear beats shift, else hold
  assign asr_val = {acc[39], acc[39:1]};

  always_comb begin
    next_acc = acc;
    if (i_cmd.clr) begin
      next_acc = '0;
    end else if (i_cmd.asr) begin
      next_acc = asr_val;
    end
  end

  // Value persists between instructions
  always_ff @(posedge i_clk) begin
    if (!i_rstn) begin
      acc <= `EID_MAC_RST;
    end else begin
      acc <= next_acc;
    end
  end

  assign o_acc = acc;

  // ========================================================
  // Checks
  default clocking cb @(posedge i_clk);
  endclocking
  default disable iff (!i_rstn);

  property p_mac_asr;
    i_cmd.asr && !i_cmd.clr |=>
    acc[39] == $past(acc[39]) && acc[38:0] == $past(acc[39:1]);
  endproperty
  a_mac_asr: assert property (p_mac_asr)
    else $error("shift right did not keep sign");

  property p_mac_clr;
    i_cmd.clr |=> acc == 40'h0000000000;
  endproperty
  a_mac_clr: assert property (p_mac_clr)
    else $error("clear left bits set");

  property p_mac_hold;
    !i_cmd.clr && !i_cmd.asr |=> $stable(acc);
  endproperty
  a_mac_hold: assert property (p_mac_hold)
    else $error("accumulator changed without command");

endmodule

// File: rtl/eid_map.svh
`ifndef EID_MAP_SVH
`define EID_MAP_SVH

// ==========================================================
// Opcode bytes
`define EID_OP_ESC 8'hA5
`define EID_OP_BRK 8'h00
`define EID_OP_ASR 8'h03
`define EID_OP_CLR 8'hE4
`define EID_OP_CJ0 8'hB6
`define EID_OP_CJ1 8'hB7
`define EID_OP_INCA 8'hA3
`define EID_OP_JMPA 8'h73
`define EID_OP_MVXR 8'hE0
`define EID_OP_MVXW 8'hF0
`define EID_OP_LCALL 8'h12
`define EID_OP_RET 8'h22
`define EID_OP_RETI 8'h32
`define EID_ACALL_LOW 5'h11

// ==========================================================
// Cycle counts per instruction
`define EID_CYC_STD 3'h1
`define EID_CYC_TWO 3'h2
`define EID_CYC_CJ 3'h4
`define EID_CYC_INCA 3'h3
`define EID_CYC_JMPA 3'h3
`define EID_CYC_MVX_F 3'h2
`define EID_CYC_MVX_S 3'h4
`define EID_CYC_AMVX_F 3'h3
`define EID_CYC_AMVX_S 3'h5
`define EID_CYC_ACALL 3'h3
`define EID_CYC_ACALL_X 3'h5
`define EID_CYC_LCALL 3'h4
`define EID_CYC_LCALL_X 3'h6
`define EID_CYC_RET 3'h4
`define EID_CYC_RET_X 3'h5

// ==========================================================
// Reset values
`define EID_PC_RST 16'h0000
`define EID_DP_RST 16'h0000
`define EID_MAC_RST 40'h0000000000

`endif

// File: rtl/eid_pkg.sv
package eid_pkg;

  // ========================================================
  // Sequencer states, one-hot
  typedef enum logic [4:0] {
    ST_IDLE = 5'h01,
    ST_ESC  = 5'h02,
    ST_REL  = 5'h04,
    ST_WAIT = 5'h08,
    ST_HALT = 5'h10
  } eid_state_type;

  // ========================================================
  // Command to the multiply-accumulate register
  typedef struct packed {
    logic clr;
    logic asr;
  } eid_mac_cmd_type;

  // ========================================================
  // Report of a finished instruction
  typedef struct packed {
    logic done;
    logic esc;
    logic [7:0] op;
    logic [2:0] cycles;
  } eid_retire_type;

endpackage

// File: sim/eid_prog_mem.sv
`timescale 1ns/1ps
// ==========================================================
// Program memory model: code bytes from a queue, optional gaps
module eid_prog_mem (
  input wire logic i_clk,    // Core clock
  input wire logic i_ready,  // Decoder will take a byte
  input wire logic i_slow,   // Insert random idle gaps
  output logic o_valid,      // Code byte present
  output logic [7:0] o_byte  // Code byte
);
  logic [7:0] q[$];
  logic took;

  // Bench fills the queue with whole instructions only
  task automatic push(input logic [7:0] b);
    q.push_back(b);
  endtask

  initial begin
    o_valid = 1'b0;
    o_byte = 8'h5A;
    took = 1'b0;
  end

  // A byte counts as taken where valid meets ready at an edge
  always @(posedge i_clk) begin
    took <= o_valid && i_ready;
  end

  // A byte on offer is held until taken; idle lines toggle
  always @(negedge i_clk) begin
    if (!o_valid || took) begin
      if (took) begin
        void'(q.pop_front());
      end
      if (q.size() != 0 && !(i_slow && $urandom_range(1) == 0)) begin
        o_valid = 1'b1;
        o_byte = q[0];
      end else begin
        o_valid = 1'b0;
        o_byte = ~o_byte;
      end
    end
  end
endmodule

// File: sim/escape_instruction_decoder_tb.sv
`timescale 1ns/1ps
`define CHK(nm, e, g) begin \
  checks++; \
  if ((g) !== (e)) begin \
    num_errors++; \
    $display("mismatch %s exp %h got %h", nm, e, g); \
  end \
end
// ==========================================================
// Self-checking bench for the escape decoder
module escape_instruction_decoder_tb;
  import eid_pkg::*;
  logic i_clk = 1'b0;
  logic i_rstn = 1'b0;
  logic i_byte_valid, i_ptr_sel, i_debug_en, i_resume, i_ext_stack;
  logic i_fast_space, i_pc_load, i_slow, o_byte_ready, o_ind_sel;
  logic o_carry, o_carry_we, o_halt;
  logic [7:0] i_byte, i_acc, i_ind_byte;
  logic [15:0] i_pc_val, i_dp_wdata, o_pc, o_data_pointer_zero, o_data_pointer_one;
  logic [15:0] pc, dp0, dp1;
  logic [1:0] i_dp_we;
  logic [39:0] o_mac;
  logic [39:0] mac = 40'h0;
  eid_retire_type o_retire;
  int num_errors = 0;
  int checks = 0;
  logic [7:0] tab[10] = '{8'hE0, 8'hF0, 8'h11, 8'hF1, 8'h12, 8'h22,
                          8'h32, 8'hB4, 8'hBF, 8'h04};
  logic [7:0] eops[10] = '{8'h00, 8'h03, 8'hE4, 8'hB6, 8'hB7, 8'hA3,
                           8'h73, 8'hE0, 8'hF0, 8'hA4};

  // 50 MHz core clock
  always #10 i_clk = ~i_clk;

  eid_decoder DUT (.i_clk(i_clk), .i_rstn(i_rstn),
    .i_byte_valid(i_byte_valid), .i_byte(i_byte), .i_acc(i_acc),
    .i_ind_byte(i_ind_byte), .i_ptr_sel(i_ptr_sel),
    .i_debug_en(i_debug_en), .i_resume(i_resume),
    .i_ext_stack(i_ext_stack), .i_fast_space(i_fast_space),
    .i_pc_load(i_pc_load), .i_pc_val(i_pc_val), .i_dp_we(i_dp_we),
    .i_dp_wdata(i_dp_wdata), .o_byte_ready(o_byte_ready), .o_pc(o_pc),
    .o_data_pointer_zero(o_data_pointer_zero), .o_data_pointer_one(o_data_pointer_one), .o_ind_sel(o_ind_sel),
    .o_carry(o_carry), .o_carry_we(o_carry_we), .o_halt(o_halt),
    .o_retire(o_retire), .o_mac(o_mac));

  eid_prog_mem mem (.i_clk(i_clk), .i_ready(o_byte_ready),
    .i_slow(i_slow), .o_valid(i_byte_valid), .o_byte(i_byte));

  // Expected cycle count per opcode and mode
  function automatic logic [2:0] exp_cyc(input logic esc,
                                         input logic [7:0] op);
    if (esc) begin
      case (op)
        8'hB6, 8'hB7: return 3'h4;
        8'hA3, 8'h73: return 3'h3;
        8'hE0, 8'hF0: return i_fast_space ? 3'h3 : 3'h5;
        default: return 3'h2;
      endcase
    end
    if (op[4:0] == 5'h11) return i_ext_stack ? 3'h5 : 3'h3;
    case (op)
      8'hE0, 8'hF0: return i_fast_space ? 3'h2 : 3'h4;
      8'h12: return i_ext_stack ? 3'h6 : 3'h4;
      8'h22, 8'h32: return i_ext_stack ? 3'h5 : 3'h4;
      default: return (op >= 8'hB4 && op <= 8'hBF) ? 3'h4 : 3'h1;
    endcase
  endfunction

  task automatic wrap_up();
    if (num_errors == 0 && checks > 0) begin
      $display("== PASSED ==");
    end else begin
      $display("== FAILED ==");
    end
    $finish;
  endtask

  // Core writes to PC and both pointers while idle
  task automatic setup(input logic [15:0] p, a, b);
    i_pc_load = 1'b1;
    i_pc_val = p;
    i_dp_we = 2'b01;
    i_dp_wdata = a;
    @(negedge i_clk);
    i_pc_load = 1'b0;
    i_dp_we = 2'b10;
    i_dp_wdata = b;
    @(negedge i_clk);
    i_dp_we = 2'b00;
    i_dp_wdata = ~b;
    pc = p;
    dp0 = a;
    dp1 = b;
  endtask

  // One instruction from first byte to retire, then compare all
  task automatic run(input logic esc, input logic [7:0] op, rel,
                     input logic slow);
    int n;
    logic [2:0] cyc;
    logic cmp;
    logic hlt;
    cyc = exp_cyc(esc, op);
    cmp = esc && op[7:1] == 7'h5B;
    hlt = esc && op == 8'h00 && i_debug_en;
    i_slow = slow;
    @(posedge i_clk);
    #1;
    if (esc) mem.push(8'hA5);
    mem.push(op);
    if (cmp) mem.push(rel);
    @(negedge i_clk);
    n = 0;
    while (o_retire.done !== 1'b1 && n < 40) begin
      @(negedge i_clk);
      n++;
    end
    if (!slow) `CHK("latency", int'(cyc), n)
    `CHK("cycles", cyc, o_retire.cycles)
    `CHK("esc", esc, o_retire.esc)
    `CHK("op", op, o_retire.op)
    `CHK("carry_we", cmp, o_carry_we)
    if (cmp) begin
      pc = pc + 16'h3;
      if (i_acc != i_ind_byte) pc = pc + {{8{rel[7]}}, rel};
      `CHK("carry", i_acc < i_ind_byte, o_carry)
      `CHK("ind_sel", op[0], o_ind_sel)
    end else if (esc && op == 8'h73) begin
      pc = pc + 16'h2 + {8'h00, i_acc};
    end else begin
      pc = pc + (esc ? 16'h2 : 16'h1);
    end
    if (esc && op == 8'hA3 && i_ptr_sel) dp0 = dp0 + 16'h1;
    if (esc && op == 8'hA3 && !i_ptr_sel) dp1 = dp1 + 16'h1;
    if (esc && op == 8'h03) mac = {mac[39], mac[39:1]};
    if (esc && op == 8'hE4) mac = 40'h0;
    `CHK("pc", pc, o_pc)
    `CHK("data_pointer_zero", dp0, o_data_pointer_zero)
    `CHK("data_pointer_one", dp1, o_data_pointer_one)
    `CHK("mac", mac, o_mac)
    `CHK("halt", hlt, o_halt)
    `CHK("ready", !hlt, o_byte_ready)
    if (hlt) begin
      i_resume = 1'b1;
      @(negedge i_clk);
      i_resume = 1'b0;
      n = 0;
      while (o_halt !== 1'b0 && n < 4) begin
        @(negedge i_clk);
        n++;
      end
      `CHK("resume", 1'b0, o_halt)
      `CHK("pc_resume", pc, o_pc)
    end
  endtask

  // Watchdog sized well beyond the whole test sequence
  initial begin
    #400000;
    num_errors++;
    wrap_up();
  end

  // Corner cases first, then random instruction mix
  initial begin
    int k;
    {i_acc, i_ind_byte, i_pc_val, i_dp_wdata} = '0;
    {i_ptr_sel, i_debug_en, i_resume, i_ext_stack} = '0;
    {i_fast_space, i_pc_load, i_dp_we, i_slow} = '0;
    void'($urandom(19));
    repeat (3) @(negedge i_clk);
    i_rstn = 1'b1;
    `CHK("rst", 1'b0, |{o_pc, o_data_pointer_zero, o_data_pointer_one, o_mac, o_halt})
    `CHK("rst_ready", 1'b0, o_byte_ready)
    @(negedge i_clk);
    setup(16'hFFFE, 16'h12FF, 16'hFFFF);
    run(1'b1, 8'hA3, 8'h00, 1'b0);
    i_ptr_sel = 1'b1;
    run(1'b1, 8'hA3, 8'h00, 1'b0);
    i_acc = 8'hFF;
    run(1'b1, 8'h73, 8'h00, 1'b0);
    i_ind_byte = 8'hFF;
    run(1'b1, 8'hB6, 8'h80, 1'b0);
    i_acc = 8'h34;
    i_ind_byte = 8'h56;
    run(1'b1, 8'hB7, 8'h80, 1'b0);
    run(1'b1, 8'hB6, 8'h7F, 1'b1);
    run(1'b1, 8'h00, 8'h00, 1'b0);
    i_debug_en = 1'b1;
    run(1'b1, 8'h00, 8'h00, 1'b0);
    run(1'b1, 8'h03, 8'h00, 1'b0);
    run(1'b1, 8'hE4, 8'h00, 1'b0);
    for (int m = 0; m < 8; m++) begin
      i_ext_stack = m[0];
      i_fast_space = m[1];
      foreach (tab[j]) run(m[2], tab[j], 8'h00, 1'b0);
    end
    repeat (80) begin
      i_acc = 8'($urandom);
      i_ind_byte = ($urandom_range(3) == 0) ? i_acc : 8'($urandom);
      i_ptr_sel = 1'($urandom);
      i_ext_stack = 1'($urandom);
      i_fast_space = 1'($urandom);
      i_debug_en = 1'($urandom);
      k = $urandom_range(15);
      if ($urandom_range(15) == 0) setup(16'($urandom), 16'($urandom),
                                         16'($urandom));
      if (k < 10) run(1'b1, eops[k], 8'($urandom), $urandom_range(7) == 0);
      else run(1'b0, tab[k - 10], 8'h00, 1'b0);
    end
    wrap_up();
  end
endmodule
